// File: dv/spc_link_sink.sv
// receiver model taking link words, with optional stalls
`timescale 1ns/1ps
module spc_link_sink (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic stall_i,
  input wire logic [15:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic take_o,
  output logic [15:0] word_o
);
  logic [3:0] phase;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase <= 4'h0;
      ready_o <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      ready_o <= !stall_i && (phase[1:0] != 2'b11);
    end
  end
  assign take_o = valid_i && ready_o;
  assign word_o = data_i;
endmodule : spc_link_sink

// File: dv/spc_props.sv
// port assertions of the sample path control block
`timescale 1ns/1ps
module spc_props (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] link_data_o,
  input wire logic link_valid_o,
  input wire logic link_ready_i,
  input wire logic [7:0] ila_cs_count_o,
  input wire logic link_reset_o,
  input wire logic serializer_power_down_o,
  input wire logic link_clock_gate_o,
  input wire logic multiframe_counter_reset_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_ila_count_zero: assert property (ila_cs_count_o == 8'h00)
    else $error("control bit count not zero");
  a_reset_group_tied: assert property (link_reset_o == serializer_power_down_o
    && link_reset_o == link_clock_gate_o
    && link_reset_o == multiframe_counter_reset_o)
    else $error("link reset group split");
  a_link_word_hold: assert property (link_valid_o && !link_ready_i
    |=> link_valid_o && $stable(link_data_o))
    else $error("link word dropped while stalled");
  a_pad_bits_zero: assert property (link_valid_o |-> link_data_o[6:1] == 6'h00)
    else $error("pad bits not zero");
  a_no_word_off: assert property (link_reset_o && !link_valid_o |=> !link_valid_o)
    else $error("link word while disabled");
endmodule : spc_props

// File: dv/tb.sv
// self-checking bench of the sample path control block
`timescale 1ns/1ps
module tb;
  import spc_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [8:0] core_a_sample_i = 9'h000;
  logic [8:0] core_b_sample_i = 9'h000;
  logic sample_valid_i = 1'b0;
  logic core_select_i = 1'b0;
  logic swap_active_i = 1'b0;
  logic timestamp_pin_i = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sample_ready_o, link_valid_o, link_ready_i;
  logic [15:0] link_data_o;
  logic [15:0] word;
  logic [7:0] ila_cs_count_o;
  logic dither_enable_o, dither_amplitude_select_o, dither_rounding_policy_o;
  logic timestamp_insert_enable_o, link_reset_o, serializer_power_down_o;
  logic link_clock_gate_o, multiframe_counter_reset_o, take, s, e;
  logic stall = 1'b0, ts_on = 1'b0;
  logic run = 1'b0;
  logic [4:0] dly = 5'h07;
  logic [31:0] q;
  logic [31:0] hist = 32'h0000_0000;
  logic [31:0] lf = 32'h232b_069c;
  logic [31:0] lg = 32'h232b_069c;
  logic [15:0] exp_q[$];
  logic [11:0] addr_t [4] = '{SPC_ADDR_STEER_DELAY, SPC_ADDR_DITHER,
    SPC_ADDR_TIMESTAMP, SPC_ADDR_LINK_ENABLE};
  logic [7:0] rst_t [4] = '{8'h07, 8'h00, 8'h00, 8'h01};
  int fails = 0;
  int samples_checked = 0;
  always #4 mclk_i = ~mclk_i;
  spc_top u_dut (.mclk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .core_a_sample_i,
    .core_b_sample_i, .sample_valid_i, .sample_ready_o, .core_select_i,
    .swap_active_i, .timestamp_pin_i, .link_data_o, .link_valid_o,
    .link_ready_i, .dither_enable_o, .dither_amplitude_select_o,
    .dither_rounding_policy_o, .timestamp_insert_enable_o, .ila_cs_count_o,
    .link_reset_o, .serializer_power_down_o, .link_clock_gate_o,
    .multiframe_counter_reset_o);
  spc_link_sink u_sink (.mclk_i, .sys_rst_i, .stall_i(stall),
    .data_i(link_data_o), .valid_i(link_valid_o), .ready_o(link_ready_i),
    .take_o(take), .word_o(word));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      final_report();
    end
  endtask : apb
  task automatic stream(input int n, input logic sw, input logic st);
    int k;
    @(posedge mclk_i);
    run <= 1'b1;
    swap_active_i <= sw;
    stall <= st;
    repeat (n) @(posedge mclk_i);
    if (st) chk("fifo refuses", 32'h0000_0000, {31'h0000_0000, sample_ready_o});
    run <= 1'b0;
    stall <= 1'b0;
    repeat (4) @(posedge mclk_i);
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge mclk_i);
    if (k >= 3000) begin
      fails++;
      final_report();
    end
    swap_active_i <= 1'b0;
    $display("test stream done");
  endtask : stream
  // ------------------------------------------------------------------
  // sample source and link word scoreboard
  // ------------------------------------------------------------------
  always @(posedge mclk_i) begin
    s = (swap_active_i && dly != 5'h00) ? hist[dly - 5'h01] : core_select_i;
    if (!sys_rst_i && sample_valid_i && sample_ready_o && !link_reset_o) begin
      exp_q.push_back({s ? core_b_sample_i : core_a_sample_i, 6'h00,
        ts_on & timestamp_pin_i});
    end
    hist <= {hist[30:0], core_select_i};
    lf = lfsr(lf);
    sample_valid_i <= run & lf[0];
    core_a_sample_i <= lf[9:1];
    core_b_sample_i <= lf[18:10];
    core_select_i <= lf[19];
    timestamp_pin_i <= lf[20];
  end
  always @(posedge mclk_i) begin
    if (take) begin
      chk("link word", {16'h0000, exp_q.size() > 0 ? exp_q.pop_front() : ~word},
        {16'h0000, word});
    end
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, addr_t[i], 32'h0000_0000);
      chk("reset value", {24'h00_0000, rst_t[i]}, q);
    end
    chk("link reset", 32'h0000_0000, {31'h0000_0000, link_reset_o});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, SPC_ADDR_DITHER, 32'(i));
      apb(1'b0, SPC_ADDR_DITHER, 32'h0000_0000);
      chk("dither reg", 32'(i), q);
      chk("dither out", 32'(i), {29'h0000_0000, dither_rounding_policy_o,
        dither_amplitude_select_o, dither_enable_o});
    end
    pstrb <= 4'h0;
    apb(1'b1, SPC_ADDR_DITHER, 32'h0000_0000);
    pstrb <= 4'hf;
    apb(1'b0, SPC_ADDR_DITHER, 32'h0000_0000);
    chk("strobe off write", 32'h0000_0007, q);
    $display("test dither done");
    for (int i = 0; i < 3; i++) begin
      lg = lfsr(lg);
      dly = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : lg[4:0];
      apb(1'b1, SPC_ADDR_STEER_DELAY, {27'h000_0000, dly});
      apb(1'b0, SPC_ADDR_STEER_DELAY, 32'h0000_0000);
      chk("steer reg", {27'h000_0000, dly}, q);
      stream(60, 1'b1, 1'b0);
    end
    stream(60, 1'b0, 1'b0);
    apb(1'b1, SPC_ADDR_TIMESTAMP, 32'h0000_0001);
    ts_on = 1'b1;
    stream(80, 1'b0, 1'b1);
    chk("stamp enable", 32'h0000_0001,
      {31'h0000_0000, timestamp_insert_enable_o});
    apb(1'b1, SPC_ADDR_LINK_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge mclk_i);
    chk("reset group", 32'h0000_000f, {28'h000_0000, link_reset_o,
      serializer_power_down_o, link_clock_gate_o,
      multiframe_counter_reset_o});
    stream(30, 1'b0, 1'b0);
    apb(1'b1, SPC_ADDR_LINK_ENABLE, 32'h0000_0001);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    dly = 5'h07;
    apb(1'b0, SPC_ADDR_STEER_DELAY, 32'h0000_0000);
    chk("steer after reset", 32'h0000_0007, q);
    apb(1'b0, SPC_ADDR_TIMESTAMP, 32'h0000_0000);
    chk("stamp after reset", 32'h0000_0000, q);
    $display("test second reset done");
    final_report();
  end
endmodule : tb
bind spc_top spc_props u_props (.mclk_i, .sys_rst_i, .psel, .penable,
  .prdata, .pready, .pslverr, .link_data_o, .link_valid_o, .link_ready_i,
  .ila_cs_count_o, .link_reset_o, .serializer_power_down_o,
  .link_clock_gate_o, .multiframe_counter_reset_o);

// File: hdl/spc_delay_line.sv
// tapped delay line with a selectable tap
`timescale 1ns/1ps
module spc_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32,
  parameter int SEL_W = 5
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [SEL_W-1:0] tap_i,
  output logic [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] taps [DEPTH];
  logic [WIDTH-1:0] tap_value;

  // tap 0 is the undelayed input
  assign tap_value = (tap_i == '0) ? data_i : taps[tap_i - SEL_W'(1)];
  assign data_o = tap_value;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        taps[i] <= '0;
      end
    end else begin
      taps[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        taps[i] <= taps[i-1];
      end
    end
  end

endmodule : spc_delay_line

// File: hdl/spc_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module spc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int CNT_W = 6
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [CNT_W-1:0] count_o
);

  localparam int PTR_W = CNT_W - 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_i && (count != CNT_W'(DEPTH));
  assign pop = out_ready_i && (count != '0);
  assign next_count = count + CNT_W'(push) - CNT_W'(pop);
  assign in_ready_o = (count != CNT_W'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + PTR_W'(push);
      rd_ptr <= rd_ptr + PTR_W'(pop);
      count <= next_count;
    end
  end

endmodule : spc_fifo

// File: hdl/spc_pkg.sv
// shared constants and types of the sample path control block
package spc_pkg;

  // -------------------------------------------------------------------------
  // register indices and byte addresses
  // -------------------------------------------------------------------------
  localparam logic [9:0] SPC_IDX_STEER_DELAY = 10'h09b;
  localparam logic [9:0] SPC_IDX_DITHER = 10'h09d;
  localparam logic [9:0] SPC_IDX_TIMESTAMP = 10'h160;
  localparam logic [9:0] SPC_IDX_LINK_ENABLE = 10'h200;
  localparam int SPC_ADDR_W = 12;
  localparam logic [11:0] SPC_ADDR_STEER_DELAY = {SPC_IDX_STEER_DELAY, 2'b00};
  localparam logic [11:0] SPC_ADDR_DITHER = {SPC_IDX_DITHER, 2'b00};
  localparam logic [11:0] SPC_ADDR_TIMESTAMP = {SPC_IDX_TIMESTAMP, 2'b00};
  localparam logic [11:0] SPC_ADDR_LINK_ENABLE = {SPC_IDX_LINK_ENABLE, 2'b00};

  // -------------------------------------------------------------------------
  // reset values and field positions
  // -------------------------------------------------------------------------
  localparam logic [7:0] SPC_RST_STEER_DELAY = 8'h07;
  localparam logic [7:0] SPC_RST_DITHER = 8'h00;
  localparam logic [7:0] SPC_RST_TIMESTAMP = 8'h00;
  localparam logic [7:0] SPC_RST_LINK_ENABLE = 8'h01;
  localparam int SPC_STEER_MSB = 4;
  localparam int SPC_DITHER_EN_BIT = 0;
  localparam int SPC_DITHER_AMP_BIT = 1;
  localparam int SPC_DITHER_ERR_BIT = 2;
  localparam int SPC_TS_EN_BIT = 0;
  localparam int SPC_LINK_EN_BIT = 0;

  // -------------------------------------------------------------------------
  // sample path sizes and timing
  // -------------------------------------------------------------------------
  localparam int SPC_CONV_W = 9;
  localparam int SPC_LINK_W = 16;
  localparam int SPC_STEER_DEPTH = 32;
  localparam int SPC_FIFO_DEPTH = 32;
  localparam int SPC_FIFO_CNT_W = 6;
  localparam logic [5:0] SPC_FIFO_ROOM = 6'h0004;
  localparam logic [7:0] SPC_ILA_CS_COUNT = 8'h00;

  typedef struct packed {
    logic [SPC_CONV_W-1:0] sample;
    logic [SPC_LINK_W-SPC_CONV_W-2:0] pad;
    logic stamp;
  } spc_link_word_type;

  typedef enum logic [2:0] {
    SPC_APB_IDLE = 3'b001,
    SPC_APB_WAIT = 3'b010,
    SPC_APB_DONE = 3'b100
  } spc_apb_state_type;

endpackage : spc_pkg

// File: hdl/spc_top.sv
// sample path control registers, steering select and timestamp insertion
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module spc_top
  import spc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core streams
  input wire logic [SPC_CONV_W-1:0] core_a_sample_i,
  input wire logic [SPC_CONV_W-1:0] core_b_sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic core_select_i,
  input wire logic swap_active_i,
  input wire logic timestamp_pin_i,
  // link side stream
  output logic [SPC_LINK_W-1:0] link_data_o,
  output logic link_valid_o,
  input wire logic link_ready_i,
  // core and link controls
  output logic dither_enable_o,
  output logic dither_amplitude_select_o,
  output logic dither_rounding_policy_o,
  output logic timestamp_insert_enable_o,
  output logic [7:0] ila_cs_count_o,
  output logic link_reset_o,
  output logic serializer_power_down_o,
  output logic link_clock_gate_o,
  output logic multiframe_counter_reset_o
);

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  logic [7:0] swap_steer_delay;
  logic [7:0] dither_control;
  logic [7:0] timestamp_bit_control;
  logic [7:0] serial_link_enable;
  spc_apb_state_type apb_state;
  spc_apb_state_type next_apb_state;

  function automatic logic [31:0] spc_read_mux(
    input logic [SPC_ADDR_W-1:0] addr,
    input logic [7:0] r0,
    input logic [7:0] r1,
    input logic [7:0] r2,
    input logic [7:0] r3
  );
    logic [31:0] value;
    value = 32'h0000_0000;
    case (addr)
      SPC_ADDR_STEER_DELAY: value = {24'h00_0000, r0};
      SPC_ADDR_DITHER: value = {24'h00_0000, r1};
      SPC_ADDR_TIMESTAMP: value = {24'h00_0000, r2};
      SPC_ADDR_LINK_ENABLE: value = {24'h00_0000, r3};
      default: value = 32'h0000_0000;
    endcase
    return value;
  endfunction : spc_read_mux

  function automatic logic spc_reg_hit(
    input logic [SPC_ADDR_W-1:0] addr,
    input logic [SPC_ADDR_W-1:0] target
  );
    return addr == target;
  endfunction : spc_reg_hit

  // -------------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------------
  logic access_phase;
  logic hit_steer;
  logic hit_dither;
  logic hit_stamp;
  logic hit_link;
  logic addr_mapped;
  logic wr_commit;
  logic wr_lane0;
  logic wr_steer;
  logic wr_dither;
  logic wr_stamp;
  logic wr_link;
  logic answer_now;
  logic read_now;
  logic [31:0] read_value;

  assign access_phase = psel && penable;
  assign hit_steer = spc_reg_hit(paddr, SPC_ADDR_STEER_DELAY);
  assign hit_dither = spc_reg_hit(paddr, SPC_ADDR_DITHER);
  assign hit_stamp = spc_reg_hit(paddr, SPC_ADDR_TIMESTAMP);
  assign hit_link = spc_reg_hit(paddr, SPC_ADDR_LINK_ENABLE);
  assign addr_mapped = hit_steer || hit_dither || hit_stamp || hit_link;
  assign wr_commit = access_phase && pready && pwrite && addr_mapped;
  assign wr_lane0 = wr_commit && pstrb[0];
  assign wr_steer = wr_lane0 && hit_steer;
  assign wr_dither = wr_lane0 && hit_dither;
  assign wr_stamp = wr_lane0 && hit_stamp;
  assign wr_link = wr_lane0 && hit_link;
  // answer only from idle, so a held access is answered once
  assign answer_now = (apb_state == SPC_APB_IDLE) && access_phase;
  assign read_now = answer_now && !pwrite;
  assign read_value = spc_read_mux(paddr, swap_steer_delay, dither_control,
                                   timestamp_bit_control, serial_link_enable);

  always_comb begin
    next_apb_state = apb_state;
    case (apb_state)
      SPC_APB_IDLE: begin
        if (access_phase) begin
          next_apb_state = SPC_APB_WAIT;
        end
      end
      SPC_APB_WAIT: next_apb_state = SPC_APB_IDLE;
      SPC_APB_DONE: next_apb_state = SPC_APB_IDLE;
      default: next_apb_state = SPC_APB_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      apb_state <= SPC_APB_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  // -------------------------------------------------------------------------
  // apb answer and register write
  // -------------------------------------------------------------------------

  // pready rises one cycle into the access phase and stays one cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= answer_now;
      pslverr <= answer_now && !addr_mapped;
      prdata <= read_now ? read_value : 32'h0000_0000;
    end
  end

  // reserved bits are stored and read back as written
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      swap_steer_delay <= SPC_RST_STEER_DELAY;
      dither_control <= SPC_RST_DITHER;
      timestamp_bit_control <= SPC_RST_TIMESTAMP;
      serial_link_enable <= SPC_RST_LINK_ENABLE;
    end else begin
      if (wr_steer) begin
        swap_steer_delay <= pwdata[7:0];
      end
      if (wr_dither) begin
        dither_control <= pwdata[7:0];
      end
      if (wr_stamp) begin
        timestamp_bit_control <= pwdata[7:0];
      end
      if (wr_link) begin
        serial_link_enable <= pwdata[7:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // core and link controls
  // -------------------------------------------------------------------------
  logic link_on;
  logic stamp_on;

  assign link_on = serial_link_enable[SPC_LINK_EN_BIT];
  assign stamp_on = timestamp_bit_control[SPC_TS_EN_BIT];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dither_enable_o <= 1'b0;
      dither_amplitude_select_o <= 1'b0;
      dither_rounding_policy_o <= 1'b0;
      timestamp_insert_enable_o <= 1'b0;
      ila_cs_count_o <= SPC_ILA_CS_COUNT;
      link_reset_o <= 1'b1;
      serializer_power_down_o <= 1'b1;
      link_clock_gate_o <= 1'b1;
      multiframe_counter_reset_o <= 1'b1;
    end else begin
      dither_enable_o <= dither_control[SPC_DITHER_EN_BIT];
      dither_amplitude_select_o <= dither_control[SPC_DITHER_AMP_BIT];
      dither_rounding_policy_o <= dither_control[SPC_DITHER_ERR_BIT];
      timestamp_insert_enable_o <= stamp_on;
      ila_cs_count_o <= SPC_ILA_CS_COUNT;
      link_reset_o <= !link_on;
      serializer_power_down_o <= !link_on;
      link_clock_gate_o <= !link_on;
      multiframe_counter_reset_o <= !link_on;
    end
  end

  // -------------------------------------------------------------------------
  // steering select
  // -------------------------------------------------------------------------
  logic delayed_select;
  logic steer_select;

  spc_delay_line #(
    .WIDTH(1),
    .DEPTH(SPC_STEER_DEPTH),
    .SEL_W(SPC_STEER_MSB + 1)
  ) u_steer_delay (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .data_i(core_select_i),
    .tap_i(swap_steer_delay[SPC_STEER_MSB:0]),
    .data_o(delayed_select)
  );

  // delayed select only during a swap, raw select otherwise
  assign steer_select = swap_active_i ? delayed_select : core_select_i;

  // -------------------------------------------------------------------------
  // sample pipeline and timestamp alignment
  // -------------------------------------------------------------------------
  logic stamp_sync1;
  logic stamp_sync2;
  logic [SPC_CONV_W-1:0] stage1_sample;
  logic [SPC_CONV_W-1:0] stage2_sample;
  logic stage1_valid;
  logic stage2_valid;
  logic sample_take;
  spc_link_word_type link_word;
  logic fifo_in_ready;
  logic [SPC_FIFO_CNT_W-1:0] fifo_count;
  logic fifo_has_room;

  assign sample_take = sample_valid_i && sample_ready_o && link_on;
  assign fifo_has_room =
    fifo_count < (SPC_FIFO_CNT_W'(SPC_FIFO_DEPTH) - SPC_FIFO_ROOM);

  // pin timestamp passes two flops, samples two stages: equal latency
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stamp_sync1 <= 1'b0;
      stamp_sync2 <= 1'b0;
    end else begin
      stamp_sync1 <= timestamp_pin_i;
      stamp_sync2 <= stamp_sync1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !link_on) begin
      stage1_sample <= '0;
      stage1_valid <= 1'b0;
      stage2_sample <= '0;
      stage2_valid <= 1'b0;
    end else begin
      stage1_sample <= steer_select ? core_b_sample_i : core_a_sample_i;
      stage1_valid <= sample_take;
      stage2_sample <= stage1_sample;
      stage2_valid <= stage1_valid;
    end
  end

  // sample kept whole in the upper bits, stamp in bit zero
  always_comb begin
    link_word.sample = stage2_sample;
    link_word.pad = '0;
    link_word.stamp = stamp_on && stamp_sync2;
  end

  // input ready leaves room for the samples already in flight
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= link_on && fifo_has_room;
    end
  end

  // -------------------------------------------------------------------------
  // output fifo and registered link port
  // -------------------------------------------------------------------------
  logic [SPC_LINK_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic link_advance;

  assign link_advance = !link_valid_o || link_ready_i;
  assign fifo_pop = fifo_out_valid && link_advance;

  spc_fifo #(
    .WIDTH(SPC_LINK_W),
    .DEPTH(SPC_FIFO_DEPTH),
    .CNT_W(SPC_FIFO_CNT_W)
  ) u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(!link_on),
    .in_data_i(link_word),
    .in_valid_i(stage2_valid && fifo_in_ready),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(link_advance),
    .count_o(fifo_count)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !link_on) begin
      link_valid_o <= 1'b0;
      link_data_o <= '0;
    end else if (link_advance) begin
      link_valid_o <= fifo_pop;
      link_data_o <= fifo_out_data;
    end
  end

endmodule : spc_top
